/* core/bcirq_top.sv */
// controller interrupt registers, time match compare and shared interrupt line
`timescale 1ns/1ps
module bcirq_top
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic nrst_in,
    // wishbone slave
    input wire bcirq_pkg::bcirq_wb_req_t wb_req_in,
    output bcirq_pkg::bcirq_wb_rsp_t wb_rsp_out,
    // controller side
    input wire logic [15:0] ctrl_event_in,
    input wire logic msg_done_in,
    input wire bcirq_pkg::bcirq_time_t time_count_in,
    // other register groups
    input wire logic mon_event_in,
    input wire logic rt_event_in,
    input wire logic mon_irq_req_in,
    input wire logic rt_irq_req_in,
    // interrupt log feed
    output bcirq_pkg::bcirq_log_t log_out,
    // interrupt outputs
    output logic irq_out,
    output logic irq_n_out
);
    import bcirq_pkg::*;

    logic [15:0] ctrl_en_q;
    logic [15:0] ctrl_oe_q;
    logic [15:0] ctrl_pend_q;
    logic [15:0] ctrl_pend_d;
    logic [15:0] hw_en_q;
    logic [15:0] hw_oe_q;
    logic [15:0] hw_pend_q;
    logic [15:0] hw_pend_d;
    logic [15:0] cfg_q;
    logic [15:0] match_lo_q;
    logic [15:0] match_hi_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic ctrl_req_q;
    logic irq_q;
    logic match_prev_q;
    bcirq_log_t log_q;

    logic access;
    logic [7:0] idx;
    logic addr_ok;
    logic [15:0] rd_val;
    logic [15:0] ctrl_new;
    logic ctrl_pend_clr;
    logic hw_pend_clr;
    logic match_now;
    logic match_evt;
    logic [15:0] hw_new;
    logic ctrl_line;

    // write strobe for one register index
    function automatic logic wr_hit(input logic [7:0] reg_idx);
        wr_hit = access && wb_req_in.we && addr_ok && (idx == reg_idx);
    endfunction

    // byte lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [15:0] wdat,
                                            input logic [1:0] lanes,
                                            input logic [15:0] mask);
        logic [15:0] m;
        m = old;
        if (lanes[0])
        begin
            m[7:0] = wdat[7:0];
        end
        if (lanes[1])
        begin
            m[15:8] = wdat[15:8];
        end
        merge16 = m & mask;
    endfunction

    // bus decode
    assign access = wb_req_in.cyc && wb_req_in.stb && !ack_q;
    assign idx = wb_req_in.adr[IDX_MSB:IDX_LSB];
    assign addr_ok = (wb_req_in.adr[31:IDX_MSB+1] == 22'h000000);

    always_comb
    begin
        rd_val = RST_ZERO;
        if (addr_ok)
        begin
            unique case (idx)
                IDX_HW_PEND: rd_val = hw_pend_q;
                IDX_CTRL_PEND: rd_val = ctrl_pend_q;
                IDX_HW_EN: rd_val = hw_en_q;
                IDX_CTRL_EN: rd_val = ctrl_en_q;
                IDX_HW_OE: rd_val = hw_oe_q;
                IDX_CTRL_OE: rd_val = ctrl_oe_q;
                IDX_TT_CFG: rd_val = cfg_q;
                IDX_MATCH_LO: rd_val = match_lo_q;
                IDX_MATCH_HI: rd_val = match_hi_q;
                default: rd_val = RST_ZERO;
            endcase
        end
    end

    // read clears of the pending registers
    assign ctrl_pend_clr = access && !wb_req_in.we && addr_ok
                           && (idx == IDX_CTRL_PEND);
    assign hw_pend_clr = access && !wb_req_in.we && addr_ok && (idx == IDX_HW_PEND);

    // bus answer one cycle after the request is seen
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            ack_q <= 1'b0;
            rdat_q <= DAT_ZERO;
        end
        else
        begin
            ack_q <= access;
            if (access && !wb_req_in.we)
            begin
                rdat_q <= {16'h0000, rd_val};
            end
        end
    end

    // controller enable and output enable
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            ctrl_en_q <= RST_ZERO;
            ctrl_oe_q <= RST_ZERO;
        end
        else
        begin
            if (wr_hit(IDX_CTRL_EN))
            begin
                ctrl_en_q <= merge16(ctrl_en_q, wb_req_in.dat[15:0], wb_req_in.sel[1:0],
                                     16'hffff);
            end
            if (wr_hit(IDX_CTRL_OE))
            begin
                ctrl_oe_q <= merge16(ctrl_oe_q, wb_req_in.dat[15:0], wb_req_in.sel[1:0],
                                     16'hffff);
            end
        end
    end

    // hardware enable, output enable and time base setting
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            hw_en_q <= RST_ZERO;
            hw_oe_q <= RST_ZERO;
            cfg_q <= RST_ZERO;
        end
        else
        begin
            if (wr_hit(IDX_HW_EN))
            begin
                hw_en_q <= merge16(hw_en_q, wb_req_in.dat[15:0], wb_req_in.sel[1:0],
                                   HW_EN_MASK);
            end
            if (wr_hit(IDX_HW_OE))
            begin
                hw_oe_q <= merge16(hw_oe_q, wb_req_in.dat[15:0], wb_req_in.sel[1:0],
                                   HW_OE_MASK);
            end
            if (wr_hit(IDX_TT_CFG))
            begin
                cfg_q <= merge16(cfg_q, wb_req_in.dat[15:0], wb_req_in.sel[1:0], CFG_MASK);
            end
        end
    end

    // time match registers
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            match_lo_q <= RST_ZERO;
            match_hi_q <= RST_ZERO;
        end
        else
        begin
            if (wr_hit(IDX_MATCH_LO))
            begin
                match_lo_q <= merge16(match_lo_q, wb_req_in.dat[15:0], wb_req_in.sel[1:0],
                                      16'hffff);
            end
            if (wr_hit(IDX_MATCH_HI))
            begin
                match_hi_q <= merge16(match_hi_q, wb_req_in.dat[15:0], wb_req_in.sel[1:0],
                                      16'hffff);
            end
        end
    end

    // match compare, one event on the first cycle of equality
    assign match_now = (time_count_in.lo == match_lo_q)
                       && (!cfg_q[CFG_TB32_BIT] || (time_count_in.hi == match_hi_q));
    assign match_evt = match_now && !match_prev_q && hw_en_q[HW_TMATCH_BIT];

    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            match_prev_q <= 1'b0;
        end
        else
        begin
            match_prev_q <= match_now;
        end
    end

    // controller pending, one flop per event bit
    genvar g;
    generate
        for (g = 0; g < DW; g++)
        begin : g_pend
            assign ctrl_new[g] = ctrl_event_in[g] && ctrl_en_q[g];
            assign ctrl_pend_d[g] = (ctrl_pend_q[g] && !ctrl_pend_clr) || ctrl_new[g];
        end
    endgenerate

    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            ctrl_pend_q <= RST_ZERO;
        end
        else
        begin
            ctrl_pend_q <= ctrl_pend_d;
        end
    end

    // hardware pending summary bits, set wins over read clear
    always_comb
    begin
        hw_new = RST_ZERO;
        hw_new[HW_CTRL_BIT] = |ctrl_new;
        hw_new[HW_MON_BIT] = mon_event_in;
        hw_new[HW_RT_BIT] = rt_event_in;
        hw_new[HW_TMATCH_BIT] = match_evt;
    end
    assign hw_pend_d = (hw_pend_clr ? RST_ZERO : hw_pend_q) | hw_new;

    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            hw_pend_q <= RST_ZERO;
        end
        else
        begin
            hw_pend_q <= hw_pend_d;
        end
    end

    // interrupt log entry per enabled event cycle
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            log_q <= '0;
        end
        else
        begin
            log_q.wr <= |ctrl_new;
            log_q.events <= ctrl_new;
            log_q.pend <= ctrl_pend_d;
        end
    end

    // controller line request, raised at message completion
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            ctrl_req_q <= 1'b0;
        end
        else if (msg_done_in && |(ctrl_pend_d & ctrl_oe_q))
        begin
            ctrl_req_q <= 1'b1;
        end
        else if (ctrl_pend_clr)
        begin
            ctrl_req_q <= 1'b0;
        end
    end

    // shared line from every group
    assign ctrl_line = ctrl_req_q && |(ctrl_pend_q & ctrl_oe_q);
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= ctrl_line || |(hw_pend_q & hw_oe_q)
                     || mon_irq_req_in || rt_irq_req_in;
        end
    end

    assign irq_out = irq_q;
    assign irq_n_out = !irq_q;
    assign log_out = log_q;
    assign wb_rsp_out.ack = ack_q;
    assign wb_rsp_out.dat = rdat_q;

    // checks
    property p_match_event;
        @(posedge mclk_in) disable iff (!nrst_in)
        (hw_en_q[HW_TMATCH_BIT] && match_now && !match_prev_q && !hw_pend_clr)
            |=> hw_pend_q[HW_TMATCH_BIT];
    endproperty
    a_match_event: assert property (p_match_event) else $error("match event lost");

    property p_match16;
        @(posedge mclk_in) disable iff (!nrst_in)
        (!cfg_q[CFG_TB32_BIT] && time_count_in.lo == match_lo_q) |-> match_now;
    endproperty
    a_match16: assert property (p_match16) else $error("16-bit match missed");

    property p_match32;
        @(posedge mclk_in) disable iff (!nrst_in)
        (cfg_q[CFG_TB32_BIT] && time_count_in.hi != match_hi_q) |-> !match_now;
    endproperty
    a_match32: assert property (p_match32) else $error("32-bit match ignored high");

    property p_disabled;
        @(posedge mclk_in) disable iff (!nrst_in)
        (ctrl_pend_clr && !(|(ctrl_event_in & ctrl_en_q))) |=> ctrl_pend_q == RST_ZERO;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled event pended");

    property p_sticky;
        @(posedge mclk_in) disable iff (!nrst_in)
        (!ctrl_pend_clr) |=> ((ctrl_pend_q & $past(ctrl_pend_q)) == $past(ctrl_pend_q));
    endproperty
    a_sticky: assert property (p_sticky) else $error("pending bit dropped");

    property p_log;
        @(posedge mclk_in) disable iff (!nrst_in)
        (|(ctrl_event_in & ctrl_en_q)) |=> log_q.wr && log_q.events == $past(ctrl_new);
    endproperty
    a_log: assert property (p_log) else $error("log entry missing");

    property p_summary;
        @(posedge mclk_in) disable iff (!nrst_in)
        (|(ctrl_event_in & ctrl_en_q)) |=> hw_pend_q[HW_CTRL_BIT];
    endproperty
    a_summary: assert property (p_summary) else $error("summary flag not set");

    property p_line_at_done;
        @(posedge mclk_in) disable iff (!nrst_in)
        (msg_done_in && |(ctrl_pend_d & ctrl_oe_q)) |-> ##2 !irq_n_out;
    endproperty
    a_line_at_done: assert property (p_line_at_done) else $error("line not asserted");

    property p_low_prio;
        @(posedge mclk_in) disable iff (!nrst_in)
        (ctrl_oe_q == RST_ZERO && hw_oe_q == RST_ZERO && !mon_irq_req_in && !rt_irq_req_in)
            [*2] |=> irq_n_out;
    endproperty
    a_low_prio: assert property (p_low_prio) else $error("masked event drove line");

    property p_read_clear;
        @(posedge mclk_in) disable iff (!nrst_in)
        ctrl_pend_clr |=> ack_q && rdat_q[15:0] == $past(ctrl_pend_q)
                          && ctrl_pend_q == $past(ctrl_new);
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("pending read wrong");

    property p_hold;
        @(posedge mclk_in) disable iff (!nrst_in)
        (ctrl_req_q && !ctrl_pend_clr && |(ctrl_pend_q & ctrl_oe_q)
         && $stable(ctrl_oe_q) && !wr_hit(IDX_CTRL_OE)) |=> ctrl_req_q ##1 irq_q;
    endproperty
    a_hold: assert property (p_hold) else $error("line request dropped early");
endmodule

/* core/bcirq_pkg.sv */
// constants, carrier types and contract list for the controller interrupt block
// Contract
// - time match enable bit 5 set raises an event when count equals match value
// - sixteen-bit time base compares only low match against low count
// - thirty-two-bit time base also needs high match equal to count bits 31-16
// - both match registers are host read-write and reset to zero
// - one bit position means one event in enable, pending and output enable
// - events with enable bit zero change nothing at all; mon_event_in and rt_event_in set hardware pending bits 1 and 2 with no enable
// - setting an enable bit never recognises events from before
// - each enabled controller event writes one interrupt log entry; events in the same cycle share one entry
// - enabled event ORs its bit into pending, earlier bits kept
// - enabled event ORs controller summary flag bit 0, other bits kept
// - output-enabled event asserts active-low interrupt line at message completion
// - enabled but not output-enabled events update pending and log, never the line
// - host read of pending returns contents and clears it to zero
// - one shared line is the OR of all output-enabled pending groups
// - simultaneous events are all captured, any may assert the line
package bcirq_pkg;
    localparam int unsigned DW = 16;
    localparam int unsigned IDX_LSB = 2;
    localparam int unsigned IDX_MSB = 9;
    localparam logic [7:0] IDX_HW_PEND = 8'h06;
    localparam logic [7:0] IDX_CTRL_PEND = 8'h07;
    localparam logic [7:0] IDX_HW_EN = 8'h0f;
    localparam logic [7:0] IDX_CTRL_EN = 8'h10;
    localparam logic [7:0] IDX_HW_OE = 8'h13;
    localparam logic [7:0] IDX_CTRL_OE = 8'h14;
    localparam logic [7:0] IDX_TT_CFG = 8'h39;
    localparam logic [7:0] IDX_MATCH_LO = 8'h47;
    localparam logic [7:0] IDX_MATCH_HI = 8'h48;
    localparam int unsigned HW_CTRL_BIT = 0;
    localparam int unsigned HW_MON_BIT = 1;
    localparam int unsigned HW_RT_BIT = 2;
    localparam int unsigned HW_TMATCH_BIT = 5;
    localparam int unsigned CFG_TB32_BIT = 0;
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [15:0] HW_EN_MASK = 16'h0020;
    localparam logic [15:0] HW_OE_MASK = 16'h0020;
    localparam logic [15:0] CFG_MASK = 16'h0001;
    localparam logic [31:0] DAT_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [31:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } bcirq_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } bcirq_wb_rsp_t;

    typedef struct packed {
        logic [15:0] hi;
        logic [15:0] lo;
    } bcirq_time_t;

    typedef struct packed {
        logic wr;
        logic [15:0] events;
        logic [15:0] pend;
    } bcirq_log_t;
endpackage

/* verification/bcirq_host.sv */
// host processor model: wishbone master, interrupt service and polling
`timescale 1ns/1ps
module bcirq_host
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic nrst_in,
    // wishbone master
    input wire bcirq_pkg::bcirq_wb_rsp_t wb_rsp_in,
    output bcirq_pkg::bcirq_wb_req_t wb_req_out
);
    import bcirq_pkg::*;
    initial wb_req_out = '0;
    // one classic cycle, held until ack or 50 cycles, address and data inverted on release
    task automatic bus(input logic we, input logic [31:0] adr, input logic [15:0] d,
        output logic [15:0] q, output bit ok);
        int n;
        n = 0;
        @(posedge mclk_in);
        wb_req_out <= '{1'b1, 1'b1, we, adr, 4'h3, {16'h0000, d}};
        do
        begin
            @(posedge mclk_in);
            n++;
        end
        while (wb_rsp_in.ack !== 1'b1 && n < 50);
        ok = (wb_rsp_in.ack === 1'b1);
        q = wb_rsp_in.dat[15:0];
        wb_req_out <= '{1'b0, 1'b0, 1'b0, ~adr, 4'h0, ~{16'h0000, d}};
    endtask
    // summary flag first, then controller pending
    task automatic service(output logic [15:0] hw, output logic [15:0] ctl, output bit ok);
        bit ok2;
        ok2 = 1'b1;
        ctl = 16'h0000;
        bus(1'b0, {22'h0, IDX_HW_PEND, 2'b00}, 16'h0000, hw, ok);
        if (hw[HW_CTRL_BIT] === 1'b1)
            bus(1'b0, {22'h0, IDX_CTRL_PEND, 2'b00}, 16'h0000, ctl, ok2);
        ok = ok & ok2;
    endtask
    // low priority polling, nonzero means event
    task automatic poll(output logic [15:0] ctl, output bit seen, output bit ok);
        bus(1'b0, {22'h0, IDX_CTRL_PEND, 2'b00}, 16'h0000, ctl, ok);
        seen = (ctl !== 16'h0000);
    endtask
endmodule

/* verification/bcirq_top_bench.sv */
// self-checking bench for the controller interrupt block
`timescale 1ns/1ps
module bcirq_top_bench;
    import bcirq_pkg::*;
    logic mclk_in = 1'b0;
    logic nrst_in = 1'b0;
    bcirq_wb_req_t wb_req;
    bcirq_wb_rsp_t wb_rsp;
    logic [15:0] ctrl_event = 16'h0000;
    logic msg_done = 1'b0;
    bcirq_time_t tcount = '0;
    logic mon_ev = 1'b0;
    logic rt_ev = 1'b0;
    logic mon_req = 1'b0;
    logic rt_req = 1'b0;
    bcirq_log_t log_v;
    logic irq;
    logic irq_n;
    int failures = 0;
    int check_count = 0;

    bcirq_top u_dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .wb_req_in(wb_req),
        .wb_rsp_out(wb_rsp), .ctrl_event_in(ctrl_event), .msg_done_in(msg_done),
        .time_count_in(tcount), .mon_event_in(mon_ev), .rt_event_in(rt_ev),
        .mon_irq_req_in(mon_req), .rt_irq_req_in(rt_req), .log_out(log_v),
        .irq_out(irq), .irq_n_out(irq_n));
    bcirq_host u_host (.mclk_in(mclk_in), .nrst_in(nrst_in), .wb_rsp_in(wb_rsp),
        .wb_req_out(wb_req));

    initial
    begin
        forever #12.5 mclk_in = ~mclk_in;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic hang;
        failures++;
        $display("CHECK FAILED at %0t: no bus answer", $time);
        report_and_stop();
    endtask
    task automatic wr(input logic [7:0] idx, input logic [15:0] d);
        logic [15:0] q;
        bit ok;
        u_host.bus(1'b1, {22'h0, idx, 2'b00}, d, q, ok);
        if (!ok)
            hang();
    endtask
    task automatic rd(input logic [7:0] idx, output logic [15:0] q);
        bit ok;
        u_host.bus(1'b0, {22'h0, idx, 2'b00}, 16'h0000, q, ok);
        if (!ok)
            hang();
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
    endtask
    // events for one cycle, returns where log output is visible
    task automatic pulse(input logic [15:0] v, input logic m, input logic r);
        @(posedge mclk_in);
        ctrl_event <= v;
        mon_ev <= m;
        rt_ev <= r;
        @(posedge mclk_in);
        ctrl_event <= 16'h0000;
        mon_ev <= 1'b0;
        rt_ev <= 1'b0;
        @(posedge mclk_in);
    endtask
    task automatic msg;
        @(posedge mclk_in);
        msg_done <= 1'b1;
        @(posedge mclk_in);
        msg_done <= 1'b0;
    endtask
    task automatic wait_irq(input logic lvl);
        int n;
        n = 0;
        while (irq_n !== ~lvl && n < 8)
        begin
            @(posedge mclk_in);
            n++;
        end
        chk(irq_n, !lvl, "irq line");
        if (irq_n !== !lvl)
            report_and_stop();
    endtask
    task automatic set_time(input logic [15:0] hi, input logic [15:0] lo);
        @(posedge mclk_in);
        tcount <= '{hi, lo};
        tick(3);
    endtask

    task automatic t_reset;
        logic [15:0] q;
        bit ok;
        logic [7:0] idx [5] = '{IDX_CTRL_PEND, IDX_CTRL_EN, IDX_CTRL_OE, IDX_MATCH_LO,
            IDX_MATCH_HI};
        foreach (idx[i])
        begin
            rd(idx[i], q);
            chk(q, 0, "reset value");
        end
        chk(irq_n, 1, "line idle");
        wr(IDX_MATCH_LO, 16'ha5c3);
        wr(IDX_MATCH_HI, 16'h3c5a);
        rd(IDX_MATCH_LO, q);
        chk(q, 16'ha5c3, "match low");
        rd(IDX_MATCH_HI, q);
        chk(q, 16'h3c5a, "match high");
        wr(IDX_CTRL_PEND, 16'hffff);
        rd(IDX_CTRL_PEND, q);
        chk(q, 0, "pending write");
        u_host.bus(1'b0, 32'h0000_0400, 16'h0000, q, ok);
        chk(q, 0, "unmapped");
        chk(ok, 1, "unmapped ack");
    endtask
    task automatic t_disabled;
        logic [15:0] q;
        wr(IDX_CTRL_OE, 16'hffff);
        pulse(16'h0008, 1'b0, 1'b0);
        chk(log_v.wr, 0, "log disabled");
        msg();
        tick(4);
        chk(irq_n, 1, "line disabled");
        wr(IDX_CTRL_EN, 16'h0008);
        rd(IDX_CTRL_PEND, q);
        chk(q, 0, "late enable");
        rd(IDX_HW_PEND, q);
        chk(q, 0, "no summary");
        wr(IDX_CTRL_OE, 16'h0000);
    endtask
    task automatic t_lowprio;
        logic [15:0] q;
        bit seen;
        bit ok;
        wr(IDX_CTRL_EN, 16'hffff);
        pulse(16'h0012, 1'b1, 1'b0);
        chk(log_v.wr, 1, "log write");
        chk(log_v.events, 16'h0012, "log events");
        chk(log_v.pend, 16'h0012, "log pend");
        pulse(16'h0100, 1'b0, 1'b1);
        chk(log_v.pend, 16'h0112, "pend kept");
        msg();
        tick(4);
        chk(irq_n, 1, "low prio line");
        rd(IDX_HW_PEND, q);
        chk(q, 16'h0007, "hw pending");
        u_host.poll(q, seen, ok);
        chk(q, 16'h0112, "polled");
        chk(seen, 1, "poll seen");
        chk(ok, 1, "poll ack");
        rd(IDX_CTRL_PEND, q);
        chk(q, 0, "read clear");
    endtask
    task automatic t_highprio;
        logic [15:0] hw;
        logic [15:0] ctl;
        bit ok;
        wr(IDX_CTRL_OE, 16'h0004);
        pulse(16'h0004, 1'b0, 1'b0);
        tick(3);
        chk(irq_n, 1, "before message end");
        msg();
        wait_irq(1'b1);
        tick(20);
        chk(irq_n, 0, "line held");
        chk(irq, 1, "line high");
        u_host.service(hw, ctl, ok);
        chk(ok, 1, "service ack");
        chk(hw, 16'h0001, "summary");
        chk(ctl, 16'h0004, "cause");
        wait_irq(1'b0);
        wr(IDX_CTRL_OE, 16'h0000);
    endtask
    task automatic t_shared;
        @(posedge mclk_in);
        mon_req <= 1'b1;
        wait_irq(1'b1);
        mon_req <= 1'b0;
        wait_irq(1'b0);
        rt_req <= 1'b1;
        wait_irq(1'b1);
        rt_req <= 1'b0;
        wait_irq(1'b0);
    endtask
    task automatic t_match;
        logic [15:0] q;
        wr(IDX_HW_EN, 16'h0020);
        wr(IDX_HW_OE, 16'h0020);
        wr(IDX_TT_CFG, 16'h0000);
        wr(IDX_MATCH_LO, 16'h1234);
        wr(IDX_MATCH_HI, 16'h5555);
        set_time(16'h0000, 16'h1233);
        rd(IDX_HW_PEND, q);
        chk(q, 16'h0000, "before match");
        set_time(16'h0000, 16'h1234);
        wait_irq(1'b1);
        rd(IDX_HW_PEND, q);
        chk(q, 16'h0020, "low match");
        wait_irq(1'b0);
        wr(IDX_TT_CFG, 16'h0001);
        set_time(16'h0000, 16'h0000);
        set_time(16'h0000, 16'h1234);
        rd(IDX_HW_PEND, q);
        chk(q, 16'h0000, "high differs");
        set_time(16'h5555, 16'h1234);
        rd(IDX_HW_PEND, q);
        chk(q, 16'h0020, "full match");
    endtask
    task automatic t_rerst;
        logic [15:0] q;
        logic [7:0] idx [4] = '{IDX_CTRL_PEND, IDX_CTRL_EN, IDX_CTRL_OE, IDX_MATCH_HI};
        wr(IDX_CTRL_EN, 16'h0001);
        wr(IDX_CTRL_OE, 16'h0001);
        pulse(16'h0001, 1'b0, 1'b0);
        msg();
        wait_irq(1'b1);
        nrst_in <= 1'b0;
        tick(2);
        chk(irq, 0, "reset irq");
        chk(log_v.wr, 0, "reset log");
        nrst_in <= 1'b1;
        foreach (idx[i])
        begin
            rd(idx[i], q);
            chk(q, 0, "second reset value");
        end
        chk(irq_n, 1, "line idle again");
    endtask

    initial
    begin
        tick(10);
        nrst_in <= 1'b1;
        t_reset();
        t_disabled();
        t_lowprio();
        t_highprio();
        t_shared();
        t_match();
        t_rerst();
        report_and_stop();
    end
endmodule
